// *** sim/olr_far_model.sv ***
// Far side model: copper device, remote converter and rail neighbours.
// Assumes one clock; every port rests at logic 1 between frames.
`timescale 1ns/10ps
module olr_far_model (
   input  wire logic               clk,     // Clock
   input  wire logic               rst_n,   // Power-up reset
   input  wire logic               en,      // Frame in progress
   input  wire olr_pkg::olr_lane_s send,    // Levels for the ports
   output olr_pkg::olr_lane_s      lane_r   // Levels seen by the block
);
   olr_pkg::olr_lane_s lane_nxt;  // Next port levels
   ////////////////////////////////////////////////////////////
   // Idle high outside frames, so no stale level lingers
   always_comb begin
      lane_nxt = en ? send : 3'h7;
   end
   // Levels change only after an edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lane_r <= 3'h7;
      end else begin
         lane_r <= lane_nxt;
      end
   end
endmodule : olr_far_model

// *** sim/olr_router_chk.sv ***
// Checker for the router outputs against pin inputs.
// Assumes inputs change at most once every 8 cycles.
`timescale 1ns/10ps
module olr_router_chk (
   input wire logic               clk,                     // Clock
   input wire logic               rst_n,                   // Reset
   input wire logic               topology_select_switch,  // Star
   input wire logic               idle_polarity_switch,    // Dark-idle
   input wire logic               tx_power_switch,         // Multimode
   input wire logic [1:0]         rx_quality,              // Grade
   input wire logic               fiber_loss,              // Broken fiber
   input wire olr_pkg::olr_lane_s lane_in,                 // Received
   input wire olr_pkg::olr_lane_s lane_out,                // Sent
   input wire logic               fiber_light,             // Light
   input wire logic               tx_power_multimode,      // Power level
   input wire logic               rail_enable,             // Rail on
   input wire olr_pkg::olr_bar_s  link_quality_bar,        // Lamps
   input wire logic               relay_closed,            // Contact
   input wire logic               config_valid             // Captured
);
   logic [6:0] hist_r [9];  // Sampled inputs, newest first
   logic [2:0] cap_r;       // Switches seen at capture
   logic       st;          // Inputs steady over the answer window
   logic [3:0] bar_exp;     // Light-idle lamp pattern
   ////////////////////////////////////////////////////////////
   // History is cleared so a reset never looks steady
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hist_r <= '{default: 7'h00};
         cap_r  <= 3'h0;
      end else begin
         hist_r[0] <= {config_valid, rx_quality, fiber_loss, lane_in};
         for (int i = 1; i < 9; i++) begin
            hist_r[i] <= hist_r[i-1];
         end
         if (config_valid && !hist_r[0][6]) begin
            cap_r <= {topology_select_switch, idle_polarity_switch, tx_power_switch};
         end
      end
   end
   assign st = hist_r[8][6] && (hist_r[2] == hist_r[8]);
   assign bar_exp = hist_r[2][3] ? 4'h1 : (hist_r[2][5:4] == 2'h0) ? 4'he :
                    (hist_r[2][5:4] == 2'h1) ? 4'h6 : (hist_r[2][5:4] == 2'h2) ? 4'h2 : 4'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   AST_LINE: assert property (st && !rail_enable |-> lane_out.rail &&
      lane_out.fiber == hist_r[2][2] && lane_out.copper == hist_r[2][1])
      else $error("line path wrong");
   AST_STAR: assert property (st && rail_enable |-> lane_out.rail == (hist_r[2][2] & hist_r[2][1]) &&
      lane_out.fiber == (hist_r[2][2] & hist_r[2][0]) && lane_out.copper == (hist_r[2][1] & hist_r[2][0]))
      else $error("star path wrong");
   AST_MODE: assert property (config_valid && hist_r[0][6] |-> rail_enable == cap_r[2])
      else $error("rail enable wrong");
   AST_POL: assert property (config_valid && hist_r[0][6] |-> fiber_light == (lane_out.fiber ^ cap_r[1]))
      else $error("idle polarity wrong");
   AST_GRADE: assert property (st && !cap_r[1] |-> link_quality_bar == bar_exp)
      else $error("bar grade wrong");
   AST_DARK: assert property (st && cap_r[1] |-> link_quality_bar == (bar_exp & 4'h1))
      else $error("dark-idle bar wrong");
   AST_RELAY: assert property (st |-> relay_closed == !(hist_r[2][5] || hist_r[2][3]))
      else $error("relay wrong");
   // Rail enable trails the capture by one register, so wait two cycles
   AST_FROZEN: assert property (config_valid && $past(config_valid, 2) |->
      $stable(tx_power_multimode) && $stable(rail_enable))
      else $error("config moved");
   AST_TXPWR: assert property (config_valid && hist_r[0][6] |-> tx_power_multimode == cap_r[0])
      else $error("power level wrong");
endmodule : olr_router_chk

// *** sim/olr_router_tb.sv ***
// Testbench: random traffic, quality grades and power cycles.
// Assumes the far model idles every port high.
`timescale 1ns/10ps
module olr_router_tb;
   logic clk = 1'b0, rst_n = 1'b0, sw_top = 1'b0, sw_pol = 1'b0, sw_pwr = 1'b0, loss = 1'b0, far_en = 1'b0;
   logic [2:0] sw_res = 3'h0, cap;       // Reserved switches, captured set
   logic [1:0] rx_q = 2'h0;              // Quality grade
   olr_pkg::olr_lane_s far_send = 3'h7, lane_in, lane_out;
   olr_pkg::olr_bar_s  bar;              // Lamps
   logic fiber_light, tx_pm, rail_en, relay, cfg_v;
   int err_count = 0, check_count = 0, n, seed = 32'ha2822b2f;
   ////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   olr_far_model u_far (.clk(clk), .rst_n(rst_n), .en(far_en), .send(far_send), .lane_r(lane_in));
   olr_router u_dut (.clk(clk), .rst_n(rst_n), .topology_select_switch(sw_top), .idle_polarity_switch(sw_pol),
      .tx_power_switch(sw_pwr), .reserved_switch(sw_res), .rx_quality(rx_q), .fiber_loss(loss), .lane_in(lane_in),
      .lane_out(lane_out), .fiber_light(fiber_light), .tx_power_multimode(tx_pm), .rail_enable(rail_en),
      .link_quality_bar(bar), .relay_closed(relay), .config_valid(cfg_v));
   // Star ports see the AND of the other two; line keeps rail idle
   function automatic olr_pkg::olr_lane_s exp_lane(input olr_pkg::olr_lane_s i, input logic star);
      exp_lane = {i.fiber & (i.rail | !star), i.copper & (i.rail | !star), !star | (i.copper & i.fiber)};
   endfunction : exp_lane
   function automatic logic [3:0] exp_bar(input logic [1:0] q, input logic ls, input logic dark);
      exp_bar = (ls || q == 2'h3) ? 4'h1 : dark ? 4'h0 : (q == 2'h0) ? 4'he : (q == 2'h1) ? 4'h6 : 4'h2;
   endfunction : exp_bar
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////
   // Power cycle: switches only count when set before capture
   task automatic power_up(input logic [2:0] sw);
      @(posedge clk);
      rst_n <= 1'b0;
      {sw_top, sw_pol, sw_pwr} <= sw;
      cap <= sw;
      sw_res <= 3'($random(seed));
      repeat (10) @(posedge clk);
      #1;
      chk({rail_en, tx_pm, relay, cfg_v}, 4'h0);
      chk({fiber_light, lane_out}, 4'hf);
      @(posedge clk);
      rst_n <= 1'b1;
      for (n = 0; n < 300 && cfg_v !== 1'b1; n++) @(posedge clk);
      if (n == 300) begin
         err_count++;
         $display("[ERR] %0t switch capture timed out", $time);
         print_verdict();
      end
      #1;
      chk({rail_en, tx_pm}, {cap[2], cap[0]});
   endtask : power_up
   // One held input set; hand mode forces a grade with the fiber intact
   task automatic step(input logic hand, input logic [1:0] q);
      olr_pkg::olr_lane_s e;  // Expected lane levels
      @(posedge clk);
      far_send <= 3'($random(seed));
      far_en <= ($random(seed) % 4) != 0;
      rx_q <= hand ? q : 2'($random(seed));
      loss <= !hand && (($random(seed) % 5) == 0);
      sw_res <= 3'($random(seed));
      repeat (7) @(posedge clk);
      #1;
      e = exp_lane(lane_in, cap[2]);
      chk({1'b0, lane_out}, {1'b0, e});
      chk(fiber_light, e.fiber ^ cap[1]);
      chk(bar, exp_bar(rx_q, loss, cap[1]));
      chk({relay, tx_pm, rail_en}, {!(rx_q[1] | loss), cap[0], cap[2]});
   endtask : step
   ////////////////////////////////////////////////////////////
   // Each mode pair, then switches flipped without a power cycle
   initial begin
      for (int p = 0; p < 4; p++) begin
         power_up({p[1], p[0], p[1] ^ p[0]});
         for (int k = 0; k < 4; k++) step(1'b1, 2'(k));
         for (int k = 0; k < 24; k++) step(1'b0, 2'h0);
         @(posedge clk);
         {sw_top, sw_pol, sw_pwr} <= ~cap;
         for (int k = 0; k < 3; k++) step(1'b0, 2'h0);
      end
      print_verdict();
   end
endmodule : olr_router_tb
bind olr_router olr_router_chk u_chk (.clk(clk), .rst_n(rst_n), .topology_select_switch(topology_select_switch),
   .idle_polarity_switch(idle_polarity_switch), .tx_power_switch(tx_power_switch), .rx_quality(rx_quality),
   .fiber_loss(fiber_loss), .lane_in(lane_in), .lane_out(lane_out), .fiber_light(fiber_light),
   .tx_power_multimode(tx_power_multimode), .rail_enable(rail_enable), .link_quality_bar(link_quality_bar),
   .relay_closed(relay_closed), .config_valid(config_valid));

// *** src/olr_pkg.sv ***
// Package for the optical link port router and diagnostics block.
// Assumes a single 100 MHz clock domain; all users refer to names with olr_pkg::.
package olr_pkg;

   // Clock period in ns
   localparam int CLK_PERIOD_NS = 10;

   // Reset values of the captured switch settings and the relay (all off at delivery)
   localparam logic TOPOLOGY_RST  = 1'b0;  // Line mode
   localparam logic POLARITY_RST  = 1'b0;  // Light-idle
   localparam logic TX_POWER_RST  = 1'b0;  // Single-mode level
   localparam logic RELAY_RST     = 1'b0;  // Relay dropped until healthy

   // Settle time after reset before the switches are sampled
   localparam int SETTLE_NS       = 1000;
   localparam int SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W        = 7;

   // Received power grades, from the analog comparator front end
   typedef enum logic [1:0] {
      OLR_Q_VERY_GOOD = 2'b00,  // Well above reserve
      OLR_Q_GOOD      = 2'b01,  // Still above reserve
      OLR_Q_CRITICAL  = 2'b10,  // At reserve
      OLR_Q_ERROR     = 2'b11   // Below reserve or broken fiber
   } olr_quality_e;

   // Captured configuration
   typedef struct packed {
      logic star_mode;      // Three-port star topology
      logic dark_idle;      // Idle transmitter dark
      logic tx_multimode;   // Multimode transmit power
   } olr_config_s;

   // Bar graph lamps
   typedef struct packed {
      logic green_hi;   // Upper green
      logic green_lo;   // Lower green
      logic yellow;     // Yellow
      logic red;        // Error
   } olr_bar_s;

   // One serial lane per port: received and transmitted levels
   typedef struct packed {
      logic copper;   // Copper port
      logic fiber;    // Fiber port
      logic rail;     // Rail backplane bus
   } olr_lane_s;

endpackage : olr_pkg

// *** src/olr_router.sv ***
// Port router, idle polarity, power grading and fault relay of the fiber converter.
// Assumes switch and pin inputs are asynchronous; serial levels are idle-high (logic 1).
`timescale 1ns/10ps

module olr_router (
   input  wire logic                 clk,                     // 100 MHz clock
   input  wire logic                 rst_n,                   // Async reset, power-up
   input  wire logic                 topology_select_switch,  // On = star
   input  wire logic                 idle_polarity_switch,    // On = dark-idle
   input  wire logic                 tx_power_switch,         // On = multimode
   input  wire logic [2:0]           reserved_switch,         // Unused, keep off
   input  wire logic [1:0]           rx_quality,              // Graded received power
   input  wire logic                 fiber_loss,              // Fiber interruption seen
   input  wire olr_pkg::olr_lane_s   lane_in,                 // Received levels per port
   output olr_pkg::olr_lane_s        lane_out,                // Transmitted levels per port
   output logic                      fiber_light,             // Transmitter on
   output logic                      tx_power_multimode,      // Multimode power level
   output logic                      rail_enable,             // Rail driver enabled
   output olr_pkg::olr_bar_s         link_quality_bar,        // Bar graph lamps
   output logic                      relay_closed,            // Fault contact closed
   output logic                      config_valid             // Switches captured
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, change taken when 2 and 3 agree
   localparam int NSYNC = 9;                  // Three switches, grade, loss, three lanes
   logic [NSYNC-1:0] raw_in;                  // Asynchronous inputs
   logic [NSYNC-1:0] s1_r, s2_r, s3_r;        // Sync stages
   logic [NSYNC-1:0] stable_r, stable_nxt;    // Filtered values

   // Reserved switches sampled nowhere, so they cannot steer anything
   assign raw_in = {topology_select_switch, idle_polarity_switch, tx_power_switch,
                    rx_quality, fiber_loss, lane_in};

   // Only update where the last two stages agree
   always_comb begin
      stable_nxt = stable_r;
      for (int i = 0; i < NSYNC; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            stable_nxt[i] = s3_r[i];
         end
      end
   end

   // Lanes reset idle-high, others low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r     <= 9'h007;
         s2_r     <= 9'h007;
         s3_r     <= 9'h007;
         stable_r <= 9'h007;
      end else begin
         s1_r     <= raw_in;
         s2_r     <= s1_r;
         s3_r     <= s2_r;
         stable_r <= stable_nxt;
      end
   end

   wire logic               sw_topo   = stable_r[8];
   wire logic               sw_pol    = stable_r[7];
   wire logic               sw_pwr    = stable_r[6];
   wire logic [1:0]         quality   = stable_r[5:4];
   wire logic               loss      = stable_r[3];
   wire olr_pkg::olr_lane_s rx        = stable_r[2:0];

   ////////////////////////////////////////////////////////////////////////
   // Power-up capture of the switches, once only
   typedef enum logic [1:0] {
      OLR_SETTLE  = 2'b00,  // Waiting for syncs to fill
      OLR_CAPTURE = 2'b01,  // Sampling switches
      OLR_RUN     = 2'b10   // Settings frozen until next power-up
   } olr_state_e;

   olr_state_e                     state_r, state_nxt;   // Capture state
   logic [olr_pkg::SETTLE_W-1:0]   cnt_r, cnt_nxt;       // Settle counter
   olr_pkg::olr_config_s           cfg_r, cfg_nxt;       // Captured settings

   // Later switch moves are ignored; only a new power-up resamples
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      cfg_nxt   = cfg_r;
      unique case (state_r)
         OLR_SETTLE: begin
            if (cnt_r == olr_pkg::SETTLE_W'(olr_pkg::SETTLE_CYC - 1)) begin
               state_nxt = OLR_CAPTURE;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         OLR_CAPTURE: begin
            cfg_nxt.star_mode    = sw_topo;
            cfg_nxt.dark_idle    = sw_pol;
            cfg_nxt.tx_multimode = sw_pwr;
            state_nxt            = OLR_RUN;
         end
         OLR_RUN: begin
            state_nxt = OLR_RUN;              // Held until reset
         end
         default: begin
            state_nxt = OLR_SETTLE;
         end
      endcase
   end

   // Default settings all off until captured
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r              <= OLR_SETTLE;
         cnt_r                <= '0;
         cfg_r.star_mode      <= olr_pkg::TOPOLOGY_RST;
         cfg_r.dark_idle      <= olr_pkg::POLARITY_RST;
         cfg_r.tx_multimode   <= olr_pkg::TX_POWER_RST;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         cfg_r   <= cfg_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Routing and status outputs
   olr_pkg::olr_lane_s tx_nxt;       // Next lane levels
   logic               light_nxt;    // Next transmitter state
   olr_pkg::olr_bar_s  bar_nxt;      // Next bar graph
   logic               relay_nxt;    // Next relay state
   olr_pkg::olr_lane_s tx_r;
   logic               light_r, relay_r, rail_r;
   olr_pkg::olr_bar_s  bar_r;

   // Data path never looks at quality, so alarms never block it
   always_comb begin
      tx_nxt = '1;                                         // Idle-high everywhere
      if (cfg_r.star_mode) begin
         tx_nxt.copper = rx.fiber & rx.rail;
         tx_nxt.fiber  = rx.copper & rx.rail;
         tx_nxt.rail   = rx.copper & rx.fiber;
      end else begin
         tx_nxt.copper = rx.fiber;
         tx_nxt.fiber  = rx.copper;
         tx_nxt.rail   = 1'b1;                             // Rail left idle
      end
      // Logic 1 is light or dark depending on polarity
      light_nxt = cfg_r.dark_idle ? ~tx_nxt.fiber : tx_nxt.fiber;

      bar_nxt   = '0;
      relay_nxt = 1'b0;
      if (loss || quality == olr_pkg::OLR_Q_ERROR) begin
         bar_nxt.red = 1'b1;
      end else if (!cfg_r.dark_idle) begin
         unique case (olr_pkg::olr_quality_e'(quality))
            olr_pkg::OLR_Q_VERY_GOOD: begin
               bar_nxt   = '{1'b1, 1'b1, 1'b1, 1'b0};
               relay_nxt = 1'b1;
            end
            olr_pkg::OLR_Q_GOOD: begin
               bar_nxt   = '{1'b0, 1'b1, 1'b1, 1'b0};
               relay_nxt = 1'b1;
            end
            olr_pkg::OLR_Q_CRITICAL: begin
               bar_nxt.yellow = 1'b1;
            end
            olr_pkg::OLR_Q_ERROR: begin
               bar_nxt.red = 1'b1;                         // Covered above
            end
         endcase
      end else begin
         // No grading with dark idle; relay only tracks reserve and loss
         relay_nxt = (quality != olr_pkg::OLR_Q_CRITICAL);
      end
      // Contact open whenever the fiber path is interrupted
      if (loss) begin
         relay_nxt = 1'b0;
      end
   end

   // Relay held open in reset and until settings frozen (no supply)
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_r    <= '1;
         light_r <= 1'b1;
         bar_r   <= '0;
         relay_r <= olr_pkg::RELAY_RST;
         rail_r  <= 1'b0;
      end else begin
         tx_r    <= tx_nxt;
         light_r <= light_nxt;
         bar_r   <= (state_r == OLR_RUN) ? bar_nxt : '0;
         relay_r <= (state_r == OLR_RUN) & relay_nxt;
         rail_r  <= cfg_r.star_mode;
      end
   end

   assign lane_out           = tx_r;
   assign fiber_light        = light_r;
   assign tx_power_multimode = cfg_r.tx_multimode;
   assign rail_enable        = rail_r;
   assign link_quality_bar   = bar_r;
   assign relay_closed       = relay_r;
   assign config_valid       = (state_r == OLR_RUN);

endmodule : olr_router
